/* File: design/swap_xor_map.svh */
// Opcode patterns, field positions and reset values for the swap/direction/xor executor.
`ifndef SWAP_XOR_MAP_SVH
`define SWAP_XOR_MAP_SVH
`define OP_SWAP_HI      6'h0e
`define OP_XORF_HI      6'h06
`define OP_XORI_HI      4'hf
`define OP_DIR_HI       9'h000
`define OP_DEST_BIT     5
`define OP_FADDR_MSB    4
`define OP_DIR_MSB      2
`define DIR_SEL_FIRST   3'h5
`define DIR_RESET       8'hff
`define W_RESET         8'h00
`define APB_W_OFF       12'h000
`define APB_INSTR_OFF   12'h004
`define APB_STATUS_OFF  12'h008
`define APB_DIR0_OFF    12'h00c
`define APB_DIR1_OFF    12'h010
`define APB_DIR2_OFF    12'h014
`define APB_FILE_OFF    12'h080
`endif

/* File: design/swap_xor_pkg.sv */
// Types shared by the swap/direction/xor executor.
`default_nettype none
package swap_xor_pkg;
  typedef enum logic [2:0] {
    op_none_t      = 3'b000,
    op_swap_t      = 3'b001,
    op_dir_t       = 3'b010,
    op_xori_t      = 3'b011,
    op_xorf_t      = 3'b100
  } op_kind_t;
  typedef struct packed {
    op_kind_t   kind;
    logic       dest_file;
    logic [4:0] faddr;
    logic [7:0] literal;
    logic [1:0] dir_sel;
    logic       dir_ok;
  } decoded_t;
endpackage
`default_nettype wire

/* File: design/instr_decode.sv */
// Combinational decoder of the four 12-bit instruction words handled here.
`include "swap_xor_map.svh"
`default_nettype none
module instr_decode
  import swap_xor_pkg::*;
(
  // Instruction word.
  input  wire logic [11:0] instr,
  // Decoded fields.
  output var decoded_t     dec
);
  wire       is_swap = (instr[11:6] == `OP_SWAP_HI);
  wire       is_xorf = (instr[11:6] == `OP_XORF_HI);
  wire       is_xori = (instr[11:8] == `OP_XORI_HI);
  wire       is_dir  = (instr[11:3] == `OP_DIR_HI);
  wire [2:0] dsel    = instr[`OP_DIR_MSB:0];
  wire       dir_ok  = is_dir && (dsel >= `DIR_SEL_FIRST);

  assign dec = '{
    kind:      is_swap ? op_swap_t : is_xorf ? op_xorf_t :
               is_xori ? op_xori_t : is_dir ? op_dir_t : op_none_t,
    dest_file: instr[`OP_DEST_BIT],
    faddr:     instr[`OP_FADDR_MSB:0],
    literal:   instr[7:0],
    dir_sel:   2'(dsel - `DIR_SEL_FIRST),
    dir_ok:    dir_ok
  };
endmodule
`default_nettype wire

/* File: design/swap_xor_exec.sv */
// Executor for nibble swap, direction load and the two exclusive-OR instructions.
//
// Operation
// - Nibble swap exchanges the two halves of the addressed file register, no flags.
// - Swap with destination 0 writes W; destination 1 writes the file register.
// - Direction load copies W into direction register 5, 6 or 7 only; no flags.
// - Immediate exclusive-OR writes W xor literal into W and sets zero.
// - File exclusive-OR combines W with file register 0 to 31; only zero changes.
// - File exclusive-OR destination 1 writes the file, leaving W; 0 writes W.
//
// Implementation choices: the placing of the registers and register access over APB.
`include "swap_xor_map.svh"
`default_nettype none
module swap_xor_exec
  import swap_xor_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Direction registers.
  output logic      [7:0]  port_a_direction,
  output logic      [7:0]  port_b_direction,
  output logic      [7:0]  port_c_direction,
  // Zero flag.
  output logic             zero_flag
);
  // Architectural state.
  logic [7:0]  w_r;
  logic [7:0]  file_r [0:31];
  // Three direction registers, for selects 5, 6 and 7.
  logic [7:0]  dir_r [0:2];
  logic        zero_r;

  // Software-visible record of the last issued word.
  logic [11:0] last_instr_r;
  logic        bad_dir_r;

  // Bus answer registers.
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // Decoded form of the issued word.
  decoded_t    dec;

  // Compares a bus address with one register offset.
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    return (addr == off);
  endfunction

  // Tells whether a decoded word is of the given kind.
  function automatic logic kind_is(input decoded_t d, input op_kind_t k);
    return (d.kind == k);
  endfunction

  // Reads are answered from the setup cycle; writes land only at the edge that closes
  // the access cycle, where the master samples ready high.
  wire setup   = psel && !penable;
  wire access  = psel && penable && pready_r;
  wire wr_go   = access && pwrite;

  // Register decode.
  wire hit_w   = reg_hit(paddr, `APB_W_OFF);
  wire hit_ins = reg_hit(paddr, `APB_INSTR_OFF);
  wire hit_st  = reg_hit(paddr, `APB_STATUS_OFF);
  wire hit_d0  = reg_hit(paddr, `APB_DIR0_OFF);
  wire hit_d1  = reg_hit(paddr, `APB_DIR1_OFF);
  wire hit_d2  = reg_hit(paddr, `APB_DIR2_OFF);

  // The file window holds 32 word-aligned registers.
  wire hit_f   = (paddr[11:7] == 5'(`APB_FILE_OFF >> 7)) && (paddr[1:0] == 2'h0);
  // Word index within the file window.
  wire [4:0] f_idx = paddr[6:2];
  wire mapped  = hit_w | hit_ins | hit_st |
                 hit_d0 | hit_d1 | hit_d2 | hit_f;

  // Software write enables; an unmapped address enables nothing.
  wire w_wr    = wr_go && hit_w;
  wire st_wr   = wr_go && hit_st;
  wire f_wr    = wr_go && hit_f;

  // Issuing an instruction word executes it at the same edge the write lands.
  wire        exec    = wr_go && hit_ins;
  wire [11:0] instr_w = pwdata[11:0];

  // Decoding works on the write data itself, so no instruction register sits in the path.
  instr_decode u_dec (
    .instr (instr_w),
    .dec   (dec)
  );

  // Operand fetch and the three results.
  wire [7:0] fval    = file_r[dec.faddr];
  wire [7:0] swapped = {fval[3:0], fval[7:4]};
  wire [7:0] xf_res  = w_r ^ fval;
  wire [7:0] xi_res  = w_r ^ dec.literal;

  // A kind only counts while its word is being executed.
  wire       is_swap = exec && kind_is(dec, op_swap_t);
  wire       is_xorf = exec && kind_is(dec, op_xorf_t);
  wire       is_xori = exec && kind_is(dec, op_xori_t);
  wire       is_dir  = exec && kind_is(dec, op_dir_t);

  // Swap and file exclusive-OR share one destination bit; the immediate form always
  // returns its result to W.
  wire [7:0] alu_res = is_swap ? swapped : xf_res;
  wire       to_file = (is_swap || is_xorf) && dec.dest_file;
  wire       to_w    = ((is_swap || is_xorf) && !dec.dest_file) || is_xori;

  // Zero follows only the two exclusive-OR results.
  wire       xi_zero = (xi_res == 8'h00);
  wire       xf_zero = (xf_res == 8'h00);

  // A direction load with a select below the first port does nothing but mark itself.
  wire       bad_dir = is_dir && !dec.dir_ok;

  // Next W: an executed result first, then a software write, else hold.
  wire [7:0] w_nxt = to_w ? (is_xori ? xi_res : alu_res) :
                     w_wr ? pwdata[7:0] : w_r;
  // Next zero flag: an exclusive-OR result first, then a software write, else hold.
  wire       zero_nxt = is_xori ? xi_zero :
                        is_xorf ? xf_zero :
                        st_wr   ? pwdata[0] : zero_r;

  // Read words; bits above each register's width read as zero.
  wire [31:0] rd_w   = {24'h000000, w_r};
  wire [31:0] rd_ins = {20'h00000, last_instr_r};
  wire [31:0] rd_st  = {30'h00000000, bad_dir_r, zero_r};
  wire [31:0] rd_d0  = {24'h000000, dir_r[0]};
  wire [31:0] rd_d1  = {24'h000000, dir_r[1]};
  wire [31:0] rd_d2  = {24'h000000, dir_r[2]};
  wire [31:0] rd_f   = {24'h000000, file_r[f_idx]};

  // Unmapped addresses read as zero.
  wire [31:0] rd_mux = hit_w   ? rd_w :
                       hit_ins ? rd_ins :
                       hit_st  ? rd_st :
                       hit_d0  ? rd_d0 :
                       hit_d1  ? rd_d1 :
                       hit_d2  ? rd_d2 :
                       hit_f   ? rd_f : 32'h00000000;

  // W and the zero flag. Execution and software writes never meet, as they need
  // different addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r    <= `W_RESET;
      zero_r <= 1'b0;
    end else begin
      w_r    <= w_nxt;
      zero_r <= zero_nxt;
    end
  end

  // The record of the last word moves only when a word executes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_instr_r <= 12'h000;
      bad_dir_r    <= 1'b0;
    end else if (exec) begin
      last_instr_r <= instr_w;
      bad_dir_r    <= bad_dir;
    end
  end

  // File registers have no reset value, like ordinary data memory. An instruction result
  // and a software write never meet, as they need different addresses.
  always_ff @(posedge pclk) begin
    if (to_file) begin
      file_r[dec.faddr] <= alu_res;
    end else if (f_wr) begin
      file_r[f_idx] <= pwdata[7:0];
    end
  end

  // Direction registers come out of reset as all ones. Each one listens to its own
  // select value only.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dir
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dir_r[g] <= `DIR_RESET;
        end else if (is_dir && dec.dir_ok && dec.dir_sel == 2'(g)) begin
          dir_r[g] <= w_r;
        end
      end
    end
  endgenerate

  // Zero-wait answer: ready, error and read data are registered in the setup cycle and
  // stand for exactly the one access cycle. An unmapped address answers with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Every output comes straight from a register.
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign port_a_direction = dir_r[0];
  assign port_b_direction = dir_r[1];
  assign port_c_direction = dir_r[2];
  assign zero_flag        = zero_r;
endmodule
`default_nettype wire

/* File: tb/swap_xor_monitor.sv */
// Port checker for the swap/direction/xor executor.
`include "swap_xor_map.svh"
`default_nettype none
module swap_xor_monitor (
  // Clock, reset, APB and results.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_a_direction,
  input wire logic [7:0]  port_b_direction,
  input wire logic [7:0]  port_c_direction,
  input wire logic        zero_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic        setw = psel && penable && pready && pwrite;
  wire logic        ins  = setw && paddr == `APB_INSTR_OFF;
  wire logic        stw  = setw && paddr == `APB_STATUS_OFF;
  wire logic [23:0] dirs = {port_c_direction, port_b_direction, port_a_direction};
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_err_with_ready: assert property (!pready |-> !pslverr)
    else $error("stray error");
  chk_dir_hold: assert property (!ins |=> $stable(dirs))
    else $error("direction changed");
  chk_swap_no_flag: assert property (
    ins && pwdata[11:6] == 6'h0e |=> $stable(zero_flag))
    else $error("swap moved zero");
  chk_dir_no_flag: assert property (
    ins && pwdata[11:3] == 9'h000 |=> $stable(zero_flag))
    else $error("load moved zero");
  chk_zero_cause: assert property (!ins && !stw |=> $stable(zero_flag))
    else $error("zero moved");
endmodule
bind swap_xor_exec swap_xor_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .port_a_direction(port_a_direction),
  .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
  .zero_flag(zero_flag));
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the swap/direction/xor executor.
`include "swap_xor_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, zero_flag, e;
  logic [7:0]  dir_a, dir_b, dir_c;
  int          error_cnt = 0;
  int          checks = 0;
  always #25 pclk = ~pclk;
  swap_xor_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .zero_flag(zero_flag));
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end else begin
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    check(q, x);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({8'h0, dir_c, dir_b, dir_a}, 32'h00ffffff);
    for (int i = 5; i < 8; i++) begin
      wr(`APB_W_OFF, 32'h30 + i);
      wr(`APB_INSTR_OFF, i);
    end
    wr(`APB_INSTR_OFF, 32'h004);
    check({8'h0, dir_c, dir_b, dir_a}, 32'h00373635);
    rd(`APB_STATUS_OFF, 32'h2);
    wr(`APB_INSTR_OFF, 32'hf37);
    rd(`APB_STATUS_OFF, 32'h1);
    check({31'h0, zero_flag}, 32'h1);
    wr(`APB_W_OFF, 32'hb5);
    wr(`APB_INSTR_OFF, 32'hfaf);
    rd(`APB_W_OFF, 32'h1a);
    check({31'h0, e}, 32'h0);
    rd(`APB_STATUS_OFF, 32'h0);
    check({31'h0, zero_flag}, 32'h0);
    wr(`APB_FILE_OFF + 12'h00c, 32'ha5);
    wr(`APB_INSTR_OFF, 32'h383);
    rd(`APB_W_OFF, 32'h5a);
    rd(`APB_FILE_OFF + 12'h00c, 32'ha5);
    wr(`APB_INSTR_OFF, 32'h3a3);
    rd(`APB_FILE_OFF + 12'h00c, 32'h5a);
    wr(`APB_W_OFF, 32'hb5);
    wr(`APB_FILE_OFF + 12'h07c, 32'haf);
    wr(`APB_INSTR_OFF, 32'h1bf);
    rd(`APB_FILE_OFF + 12'h07c, 32'h1a);
    rd(`APB_W_OFF, 32'hb5);
    wr(`APB_INSTR_OFF, 32'h19f);
    rd(`APB_W_OFF, 32'haf);
    wr(`APB_FILE_OFF + 12'h07c, 32'haf);
    wr(`APB_INSTR_OFF, 32'h19f);
    rd(`APB_STATUS_OFF, 32'h1);
    check({31'h0, zero_flag}, 32'h1);
    rd(12'h040, 32'h0);
    check({31'h0, e}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
